// ---- core/bbt_transceiver.sv ----
/*
 * Two-direction bus transceiver core with transparent, latched and clocked
 * storage per direction, tri-state pin control and a test-mode override.
 * Assumes all pins are asynchronous to clock_i and pass a three-stage
 * synchroniser; test-mode inputs come from logic on clock_i.
 */
// Contract
// RL1: 20-bit words, one store per direction.
// RL2: Latch enable high makes B follow A.
// RL3: Clock enable high holds stored value.
// RL4: Static clock level keeps stored value.
// RL5: Rising clock with enables low captures A.
// RL6: Output enable low drives B port.
// RL7: Output enable high floats all B outputs.
// RL8: B-to-A mirrors A-to-B with own controls.
// RL9: Test mode suppresses normal path at boundary.
// RL10: Test logic idle leaves data path untouched.
// RL11: Per-direction test mode selects test values.
`timescale 1ns/1ps
`default_nettype none
module bbt_transceiver import bbt_pkg::*; #(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic reset_i,
    // A port pins.
    input wire logic [WIDTH-1:0] a_i,
    output logic [WIDTH-1:0] a_o,
    output logic a_oe_o,
    // B port pins.
    input wire logic [WIDTH-1:0] b_i,
    output logic [WIDTH-1:0] b_o,
    output logic b_oe_o,
    // A-to-B control pins.
    input wire logic a_to_b_output_enable_n_i,
    input wire logic a_to_b_latch_enable_i,
    input wire logic a_to_b_clock_enable_n_i,
    input wire logic a_to_b_clock_i,
    // B-to-A control pins.
    input wire logic b_to_a_output_enable_n_i,
    input wire logic b_to_a_latch_enable_i,
    input wire logic b_to_a_clock_enable_n_i,
    input wire logic b_to_a_clock_i,
    // Test overrides from the boundary-scan logic.
    input wire logic a_to_b_test_mode_i,
    input wire logic [WIDTH-1:0] a_to_b_test_data_i,
    input wire logic a_to_b_test_oe_i,
    input wire logic b_to_a_test_mode_i,
    input wire logic [WIDTH-1:0] b_to_a_test_data_i,
    input wire logic b_to_a_test_oe_i,
    // Capture buffer status.
    output logic a_to_b_capture_ready_o,
    output logic b_to_a_capture_ready_o
);
    localparam int PW = 2 * WIDTH + NUM_DIRS * CTRL_W;
    // Output-enable bits leave reset at their inactive level, so no pin is driven before the real pins arrive.
    localparam logic [PW-1:0] PIN_RST = PW'({RST_OE_N, {(CTRL_W - 1){RST_BIT}}, RST_OE_N, {(CTRL_W - 1){RST_BIT}},
                                            {(2 * WIDTH){RST_BIT}}});

    logic [PW-1:0] pin_raw;
    logic [PW-1:0] sync1_reg;
    logic [PW-1:0] sync2_reg;
    logic [PW-1:0] sync3_reg;
    logic [PW-1:0] filt_reg;
    logic [NUM_DIRS-1:0] clk_prev_reg;
    logic [WIDTH-1:0] store_reg [NUM_DIRS];
    logic [WIDTH-1:0] drive_reg [NUM_DIRS];
    logic [NUM_DIRS-1:0] oe_reg;
    logic [NUM_DIRS-1:0] ready_reg;
    logic [WIDTH-1:0] src [NUM_DIRS];
    logic [NUM_DIRS-1:0] oe_n;
    logic [NUM_DIRS-1:0] le;
    logic [NUM_DIRS-1:0] clken_n;
    logic [NUM_DIRS-1:0] clk;
    logic [NUM_DIRS-1:0] rise;
    logic [NUM_DIRS-1:0] capture;
    logic [NUM_DIRS-1:0] fifo_in_ready;
    logic [NUM_DIRS-1:0] fifo_out_valid;
    logic [WIDTH-1:0] fifo_out_data [NUM_DIRS];
    logic [NUM_DIRS-1:0] test_mode;
    logic [WIDTH-1:0] test_data [NUM_DIRS];
    logic [NUM_DIRS-1:0] test_oe;

    // Pin bundle: B-to-A controls, A-to-B controls, B data, A data.
    assign pin_raw = {b_to_a_output_enable_n_i, b_to_a_latch_enable_i, b_to_a_clock_enable_n_i, b_to_a_clock_i,
                      a_to_b_output_enable_n_i, a_to_b_latch_enable_i, a_to_b_clock_enable_n_i, a_to_b_clock_i,
                      b_i, a_i};

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_reg <= PIN_RST;
            sync2_reg <= PIN_RST;
            sync3_reg <= PIN_RST;
        end else begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // A bit changes only once the second and third stages agree, which rejects single-cycle glitches.
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            filt_reg <= PIN_RST;
        end else begin
            filt_reg <= (sync3_reg & ~(sync2_reg ^ sync3_reg)) | (filt_reg & (sync2_reg ^ sync3_reg));
        end
    end

    assign test_mode = {b_to_a_test_mode_i, a_to_b_test_mode_i};
    assign test_data[0] = a_to_b_test_data_i;
    assign test_data[1] = b_to_a_test_data_i;
    assign test_oe = {b_to_a_test_oe_i, a_to_b_test_oe_i};

    for (genvar d = 0; d < NUM_DIRS; d++) begin : g_dir // [RL8]
        assign src[d] = filt_reg[d * WIDTH +: WIDTH]; // [RL1]
        assign clk[d] = filt_reg[2 * WIDTH + d * CTRL_W];
        assign clken_n[d] = filt_reg[2 * WIDTH + d * CTRL_W + 1];
        assign le[d] = filt_reg[2 * WIDTH + d * CTRL_W + 2];
        assign oe_n[d] = filt_reg[2 * WIDTH + d * CTRL_W + 3];
        assign rise[d] = clk[d] & ~clk_prev_reg[d];
        // Only a rising edge with both enables low stores a word; static clock levels store nothing.
        assign capture[d] = ~le[d] & ~clken_n[d] & rise[d]; // [RL3] [RL4] [RL5]

        // Captured words queue here; while test mode holds the drain the queue fills and ready drops.
        bbt_fifo #(
            .WIDTH(WIDTH),
            .DEPTH(DEPTH)
        ) u_fifo (
            .clock_i(clock_i),
            .reset_i(reset_i),
            .in_valid_i(capture[d]),
            .in_ready_o(fifo_in_ready[d]),
            .in_data_i(src[d]),
            .out_valid_o(fifo_out_valid[d]),
            .out_ready_i(~test_mode[d]),
            .out_data_o(fifo_out_data[d])
        );

        always_ff @(posedge clock_i or posedge reset_i) begin
            if (reset_i) begin
                clk_prev_reg[d] <= RST_BIT;
            end else begin
                clk_prev_reg[d] <= clk[d];
            end
        end

        // Queued edge captures are applied before transparent tracking so none is skipped.
        always_ff @(posedge clock_i or posedge reset_i) begin
            if (reset_i) begin
                store_reg[d] <= '0;
            end else if (!test_mode[d]) begin // [RL9]
                if (fifo_out_valid[d]) begin
                    store_reg[d] <= fifo_out_data[d]; // [RL5]
                end else if (le[d]) begin
                    store_reg[d] <= src[d]; // [RL2]
                end
            end
        end

        always_ff @(posedge clock_i or posedge reset_i) begin
            if (reset_i) begin
                drive_reg[d] <= '0;
                oe_reg[d] <= ~RST_OE_N;
                ready_reg[d] <= RST_BIT;
            end else begin
                drive_reg[d] <= test_mode[d] ? test_data[d] : store_reg[d]; // [RL6] [RL11]
                oe_reg[d] <= test_mode[d] ? test_oe[d] : ~oe_n[d]; // [RL7] [RL11] [RL10]
                ready_reg[d] <= fifo_in_ready[d];
            end
        end
    end

    assign b_o = drive_reg[0];
    assign b_oe_o = oe_reg[0];
    assign a_o = drive_reg[1];
    assign a_oe_o = oe_reg[1];
    assign a_to_b_capture_ready_o = ready_reg[0];
    assign b_to_a_capture_ready_o = ready_reg[1];

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    sequence s_transp_steady;
        le[0] && !test_mode[0] && !fifo_out_valid[0] && $stable(src[0]);
    endsequence
    sequence s_normal_two;
        !test_mode[0] [*2];
    endsequence

    a_transp_follow: assert property (s_transp_steady ##1 s_normal_two |-> b_o == $past(src[0], 2)) // [RL2]
        else $error("B output does not follow A in transparent mode.");
    a_hold_clken: assert property (!le[0] && clken_n[0] && !fifo_out_valid[0] && !test_mode[0]
        |=> $stable(store_reg[0])) // [RL3]
        else $error("Stored A-to-B word changed while clock enable was high.");
    a_hold_static: assert property (!le[0] && !rise[0] && !fifo_out_valid[0] && !test_mode[0]
        |=> $stable(store_reg[0])) // [RL4]
        else $error("Stored A-to-B word changed without a clock edge.");
    a_edge_capture: assert property (capture[0] && fifo_in_ready[0] && !fifo_out_valid[0] && !test_mode[0]
        ##1 !test_mode[0] |=> store_reg[0] == $past(src[0], 2)) // [RL5]
        else $error("Rising clock did not store the A word.");
    a_oe_drive: assert property (!oe_n[0] && !test_mode[0] |=> b_oe_o) // [RL6]
        else $error("B outputs not driven with output enable low.");
    a_oe_float: assert property (oe_n[0] && !test_mode[0] |=> !b_oe_o) // [RL7]
        else $error("B outputs driven with output enable high.");
    a_mirror_oe: assert property (oe_n[1] && !test_mode[1] |=> !a_oe_o) // [RL8]
        else $error("A outputs driven with reverse output enable high.");
    a_test_freeze: assert property (test_mode[0] |=> $stable(store_reg[0])) // [RL9]
        else $error("Normal A-to-B storage changed in test mode.");
    a_test_values: assert property (a_to_b_test_mode_i |=> b_o == $past(a_to_b_test_data_i)
        && b_oe_o == $past(a_to_b_test_oe_i)) // [RL11]
        else $error("Test values not presented at the B boundary.");
    a_normal_path: assert property (!test_mode[1] |=> a_o == $past(store_reg[1])) // [RL10]
        else $error("Normal B-to-A output path altered outside test mode.");
endmodule : bbt_transceiver
`default_nettype wire

// ---- pkg/bbt_pkg.sv ----
/*
 * Shared constants of the bidirectional bus transceiver: data width,
 * synchroniser depth, buffer depth and reset values.
 * Assumes a single 250 MHz system clock drives everything that uses it.
 */
package bbt_pkg;
    localparam int DATA_W = 20;
    localparam int FIFO_DEPTH = 32;
    localparam int SYNC_STAGES = 3;
    localparam int CTRL_W = 4;
    localparam int NUM_DIRS = 2;
    localparam int CLK_PERIOD_NS = 4;
    localparam logic RST_BIT = 1'h0;
    localparam logic RST_OE_N = 1'h1;
endpackage : bbt_pkg

// ---- core/bbt_fifo.sv ----
/*
 * Parameterised first-word-fall-through FIFO with valid and ready on both
 * sides; the read data always come from a register.
 * Assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module bbt_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 32
) (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic reset_i,
    // Fill side.
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side.
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [CW-1:0] count_reg;
    logic out_valid_reg;
    logic [WIDTH-1:0] out_data_reg;
    logic push;
    logic pop;
    logic slot_free;
    logic mem_rd;
    logic bypass;
    logic mem_wr;

    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_reg & out_ready_i;
    assign slot_free = ~out_valid_reg | pop;
    assign mem_rd = slot_free & (count_reg != '0);
    // A word goes straight to the output slot only when nothing is queued ahead of it.
    assign bypass = slot_free & (count_reg == '0) & push;
    assign mem_wr = push & ~bypass;
    assign in_ready_o = (count_reg != CW'(DEPTH));
    assign out_valid_o = out_valid_reg;
    assign out_data_o = out_data_reg;

    always_ff @(posedge clock_i) begin
        if (mem_wr) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (mem_wr) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (mem_rd) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + CW'(mem_wr) - CW'(mem_rd);
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            out_valid_reg <= 1'h0;
            out_data_reg <= '0;
        end else if (slot_free) begin
            out_valid_reg <= mem_rd | bypass;
            if (mem_rd) begin
                out_data_reg <= mem_reg[rd_ptr_reg];
            end else if (bypass) begin
                out_data_reg <= in_data_i;
            end
        end
    end
endmodule : bbt_fifo
`default_nettype wire

// ---- verif/bbt_bus_model.sv ----
/*
 * Far-side model of the system buses on the A and B ports.
 * Assumes the bench sets host values by non-blocking assignment on clock_i.
 */
`timescale 1ns/1ps
`default_nettype none
module bbt_bus_model import bbt_pkg::*; (
    // Clock.
    input wire logic clock_i,
    // Transceiver drivers.
    input wire logic [DATA_W-1:0] a_drv_i,
    input wire logic a_drv_en_i,
    input wire logic [DATA_W-1:0] b_drv_i,
    input wire logic b_drv_en_i,
    // Host drivers.
    input wire logic [DATA_W-1:0] host_a_i,
    input wire logic host_a_en_i,
    input wire logic [DATA_W-1:0] host_b_i,
    input wire logic host_b_en_i,
    // Resolved bus levels.
    output logic [DATA_W-1:0] a_bus_o,
    output logic [DATA_W-1:0] b_bus_o
);
    logic [DATA_W-1:0] a_last_reg;
    logic [DATA_W-1:0] b_last_reg;

    // A floating bus toggles every cycle, so stale data never looks driven.
    always_ff @(posedge clock_i) begin
        a_last_reg <= a_bus_o;
        b_last_reg <= b_bus_o;
    end

    assign a_bus_o = (a_drv_en_i && host_a_en_i) ? 'x : a_drv_en_i ? a_drv_i : host_a_en_i ? host_a_i : ~a_last_reg;
    assign b_bus_o = (b_drv_en_i && host_b_en_i) ? 'x : b_drv_en_i ? b_drv_i : host_b_en_i ? host_b_i : ~b_last_reg;
endmodule : bbt_bus_model
`default_nettype wire

// ---- verif/testbench.sv ----
/*
 * Self-checking bench of the transceiver: mode table per direction, test
 * override, capture buffer overflow. Assumes the bus model on both ports.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench import bbt_pkg::*; ();
    typedef struct {
        logic oe_n;
        logic le;
        logic cke_n;
        logic pulse;
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] exp;
        logic exp_oe;
    } bbt_row_s;
    logic clock_i = 1'h0;
    logic reset_i = 1'h1;
    logic [1:0] oe_n = 2'h3;
    logic [1:0] le = 2'h0;
    logic [1:0] cke_n = 2'h3;
    logic [1:0] sclk = 2'h0;
    logic [1:0] tm = 2'h0;
    logic [1:0] toe = 2'h0;
    logic [1:0] hen = 2'h0;
    logic [1:0] cr;
    logic [DATA_W-1:0] td [2] = '{default: '0};
    logic [DATA_W-1:0] hv [2] = '{default: '0};
    logic [DATA_W-1:0] a_i, a_o, b_i, b_o;
    logic a_oe_o, b_oe_o;
    int fails = 0;
    int compares = 0;
    bbt_row_s rows [7] = '{
        '{1'h0, 1'h1, 1'h1, 1'h0, 20'h12345, 20'h12345, 1'h1},
        '{1'h0, 1'h0, 1'h1, 1'h0, 20'hABCDE, 20'h12345, 1'h1},
        '{1'h0, 1'h0, 1'h1, 1'h1, 20'hABCDE, 20'h12345, 1'h1},
        '{1'h0, 1'h0, 1'h0, 1'h0, 20'h55555, 20'h12345, 1'h1},
        '{1'h0, 1'h0, 1'h0, 1'h1, 20'h55555, 20'h55555, 1'h1},
        '{1'h1, 1'h1, 1'h1, 1'h0, 20'hFFFFF, 20'hFFFFF, 1'h0},
        '{1'h0, 1'h1, 1'h1, 1'h0, 20'h00000, 20'h00000, 1'h1}};

    bbt_transceiver u_bbt_transceiver (.clock_i(clock_i), .reset_i(reset_i), .a_i(a_i), .a_o(a_o),
        .a_oe_o(a_oe_o), .b_i(b_i), .b_o(b_o), .b_oe_o(b_oe_o),
        .a_to_b_output_enable_n_i(oe_n[0]), .a_to_b_latch_enable_i(le[0]),
        .a_to_b_clock_enable_n_i(cke_n[0]), .a_to_b_clock_i(sclk[0]),
        .b_to_a_output_enable_n_i(oe_n[1]), .b_to_a_latch_enable_i(le[1]),
        .b_to_a_clock_enable_n_i(cke_n[1]), .b_to_a_clock_i(sclk[1]),
        .a_to_b_test_mode_i(tm[0]), .a_to_b_test_data_i(td[0]), .a_to_b_test_oe_i(toe[0]),
        .b_to_a_test_mode_i(tm[1]), .b_to_a_test_data_i(td[1]), .b_to_a_test_oe_i(toe[1]),
        .a_to_b_capture_ready_o(cr[0]), .b_to_a_capture_ready_o(cr[1]));

    bbt_bus_model u_bbt_bus_model (.clock_i(clock_i), .a_drv_i(a_o), .a_drv_en_i(a_oe_o), .b_drv_i(b_o),
        .b_drv_en_i(b_oe_o), .host_a_i(hv[0]), .host_a_en_i(hen[0]), .host_b_i(hv[1]),
        .host_b_en_i(hen[1]), .a_bus_o(a_i), .b_bus_o(b_i));

    initial begin
        forever #2 clock_i = ~clock_i;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask : cyc

    function automatic logic [DATA_W-1:0] oval(input int d);
        return d ? a_o : b_o;
    endfunction : oval

    function automatic logic ooe(input int d);
        return d ? a_oe_o : b_oe_o;
    endfunction : ooe

    task automatic check(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Pin clock levels last four cycles, above the two the sampler needs.
    task automatic pulse(input int d);
        sclk[d] <= 1'h1;
        cyc(4);
        sclk[d] <= 1'h0;
        cyc(4);
    endtask : pulse

    task automatic end_sim;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    initial begin
        cyc(20000);
        fails++;
        end_sim();
    end

    initial begin
        cyc(6);
        @(negedge clock_i);
        check("reset oe", {a_oe_o, b_oe_o, cr}, 20'h0);
        check("reset data", a_o | b_o, 20'h0);
        cyc(2);
        reset_i <= 1'h0;
        for (int d = 0; d < 2; d++) begin
            // Both sides float before the host moves, so no bus ever sees two drivers.
            oe_n <= 2'h3;
            cyc(6);
            hen <= 2'h1 << d;
            cyc(10);
            foreach (rows[i]) begin
                oe_n[d] <= rows[i].oe_n;
                le[d] <= rows[i].le;
                cke_n[d] <= rows[i].cke_n;
                cyc(10);
                hv[d] <= rows[i].data;
                cyc(10);
                if (rows[i].pulse) pulse(d);
                @(negedge clock_i);
                check("oe", ooe(d), rows[i].exp_oe);
                if (rows[i].exp_oe) check("value", oval(d), rows[i].exp);
                cyc(1);
            end
            tm[d] <= 1'h1;
            td[d] <= 20'hA5A5A;
            toe[d] <= 1'h1;
            cyc(1);
            @(negedge clock_i);
            check("test value", oval(d), 20'hA5A5A);
            check("test oe", ooe(d), 1'h1);
            cyc(1);
            toe[d] <= 1'h0;
            cyc(1);
            @(negedge clock_i);
            check("test float", ooe(d), 1'h0);
            cyc(1);
            tm[d] <= 1'h0;
            cyc(8);
            @(negedge clock_i);
            check("normal oe", ooe(d), 1'h1);
            check("normal value", oval(d), 20'h00000);
            cyc(1);
        end
        // Stalled drain: 33 captures fill buffer and out slot, the 34th is lost.
        oe_n <= 2'h3;
        le[0] <= 1'h0;
        cke_n[0] <= 1'h0;
        tm[0] <= 1'h1;
        cyc(6);
        oe_n <= 2'h2;
        hen <= 2'h1;
        cyc(10);
        check("ready empty", cr[0], 1'h1);
        for (int i = 0; i < 34; i++) begin
            hv[0] <= 20'h00100 + 20'(i);
            cyc(4);
            pulse(0);
        end
        check("ready full", cr[0], 1'h0);
        tm[0] <= 1'h0;
        cyc(60);
        @(negedge clock_i);
        check("ready drained", cr[0], 1'h1);
        check("last capture", b_o, 20'h00120);
        end_sim();
    end
endmodule : testbench
`default_nettype wire
